// File: design/ddr_timing_defines.svh
`ifndef DDR_TIMING_DEFINES_SVH
`define DDR_TIMING_DEFINES_SVH
// Times in picoseconds as printed, clock period in ps
`define CLK_PERIOD_PS 100000
`define T_ACT_TO_RW_PS 13125
`define T_PRE_TO_ACT_PS 13125
`define T_ROW_OPEN_MIN_PS 45000
`define T_ROW_OPEN_MAX_PS 70000000
`define T_ACT_TO_ACT_PS 58125
`define T_REF_TO_ANY_PS 105000
`define T_REF_INTERVAL_PS 7800000
`define T_REF_INTERVAL_HOT_PS 3900000
`define T_MODE_SET_CK 2
`define READ_LATENCY_CK 7
`define BURST_LEN 4
`define TEST_DESELECTS 4
`define TEST_TRAILING 8
`define CK_PERIOD_MIN_PS 1875
`define CK_PERIOD_MAX_PS 7500
// Least times round up, longest times round down
`define CYC_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DN(ps) ((ps) / `CLK_PERIOD_PS)
`endif

// File: design/ddr_timing_pkg.sv
// Purpose: types shared by the command sequencer
// Assumes: four banks
// Notes: command encodings are one-hot except CMD_NOP, which is all zeros
package ddr_timing_pkg;
  typedef enum logic [5:0] {
    CMD_NOP = 6'h00,
    CMD_ACT = 6'h01,
    CMD_RD = 6'h02,
    CMD_WR = 6'h04,
    CMD_PRE = 6'h08,
    CMD_REF = 6'h10,
    CMD_MRS = 6'h20
  } cmd_t;
  typedef struct packed {
    cmd_t cmd;
    logic [1:0] bank;
    logic auto_pre;
    logic [13:0] addr;
  } cmd_req_t;
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [1:0] ba;
    logic [13:0] a;
  } dram_pins_t;
endpackage

// File: design/bank_timer.sv
// Purpose: per-bank spacing counters for activate, read/write and precharge
// Assumes: one command per cycle at most
// Notes: counters saturate at zero; open-row age counts up
`include "ddr_timing_defines.svh"
module bank_timer import ddr_timing_pkg::*; #(
  parameter int ROW_MAX_CYC = `CYC_DN(`T_ROW_OPEN_MAX_PS)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Commands seen on this bank
  input wire logic act,
  input wire logic close,
  input wire logic [6:0] close_wait,
  // Status
  output logic rw_ok,
  output logic act_ok,
  output logic pre_ok,
  output logic row_open,
  output logic row_expiring
);
  localparam logic [6:0] RCD_C = 7'(`CYC_UP(`T_ACT_TO_RW_PS));
  localparam logic [6:0] RAS_C = 7'(`CYC_UP(`T_ROW_OPEN_MIN_PS));
  localparam logic [6:0] RC_C = 7'(`CYC_UP(`T_ACT_TO_ACT_PS));
  logic [6:0] rcd_q, rcd_d, ras_q, ras_d, act_q, act_d;
  logic [31:0] age_q, age_d;
  logic open_q, open_d;
  function automatic logic [6:0] dec(input logic [6:0] v);
    return (v == 7'h00) ? 7'h00 : v - 7'h01;
  endfunction
  always_comb begin
    rcd_d = act ? RCD_C : dec(rcd_q);
    ras_d = act ? RAS_C : dec(ras_q);
    act_d = act ? RC_C : (close && close_wait > dec(act_q)) ? close_wait : dec(act_q);
    open_d = act ? 1'b1 : close ? 1'b0 : open_q;
    age_d = act ? 32'h0 : open_q ? age_q + 32'h1 : age_q;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rcd_q <= 7'h00;
      ras_q <= 7'h00;
      act_q <= 7'h00;
      open_q <= 1'b0;
      age_q <= 32'h0;
    end else begin
      rcd_q <= rcd_d;
      ras_q <= ras_d;
      act_q <= act_d;
      open_q <= open_d;
      age_q <= age_d;
    end
  end
  assign rw_ok = open_q && rcd_q <= 7'h01;
  assign pre_ok = open_q && ras_q <= 7'h01;
  assign act_ok = !open_q && act_q <= 7'h01;
  assign row_open = open_q;
  assign row_expiring = open_q && age_q + 32'd8 >= 32'(ROW_MAX_CYC);
endmodule // bank_timer

// File: design/ddr_cmd_sequencer.sv
// Purpose: DDR2 command sequencer that enforces command spacing and refresh
// Assumes: one command per core_clk; command pins are registered outputs
// Notes: a user request is held on req by the requester until its spacing has elapsed
//
// Functional notes
// - Read or write waits activate-to-access time after its bank's activate.
// - Activate waits precharge time after precharge of the same bank.
// - Row stays open between least and greatest open time.
// - Activates to one bank are spaced by the row cycle time.
// - Read latency seven cycles; activate and precharge times near seven cycles (here each rounds up to one cycle).
// - Command clock period must lie between 1875 ps and 7500 ps; CLK_PERIOD_PS here is 100000 ps.
// - After refresh, wait refresh cycle time before refresh or activate.
// - Refresh every 7.8 us, or 3.9 us when hot.
// - After mode register set, wait two cycles before any command.
// - Write strobe first edge within quarter clock of its clock edge.
// - Interleaved read test rotates all banks at row cycle time, burst four.
// - Test: per bank activate, read auto-precharge, four deselects, trailing deselects.
// - Address and control held steady during test deselects.
`include "ddr_timing_defines.svh"
module ddr_cmd_sequencer import ddr_timing_pkg::*; #(
  parameter int REFI_CYC = `CYC_DN(`T_REF_INTERVAL_PS),
  parameter int REFI_HOT_CYC = `CYC_DN(`T_REF_INTERVAL_HOT_PS),
  parameter int ROW_MAX_CYC = `CYC_DN(`T_ROW_OPEN_MAX_PS)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // User request
  input wire logic req_valid,
  input wire cmd_req_t req,
  input wire logic hot,
  input wire logic test_start,
  output logic req_ready,
  // Status
  output logic test_busy,
  output logic rd_data_due,
  // Memory command pins
  output dram_pins_t pins
);
  localparam logic [6:0] RP_C = 7'(`CYC_UP(`T_PRE_TO_ACT_PS));
  localparam logic [6:0] RFC_C = 7'(`CYC_UP(`T_REF_TO_ANY_PS));
  localparam logic [6:0] MRD_C = 7'(`T_MODE_SET_CK);
  localparam logic [7:0] TEST_LEN = 8'(4 * (2 + `TEST_DESELECTS) + `TEST_TRAILING);
  // A slow core clock: every spacing still holds, but the pins only model the command
  // stream; the DRAM clock itself must be made elsewhere in range.
  localparam bit CLK_IN_RANGE = (`CK_PERIOD_MIN_PS <= `CK_PERIOD_MAX_PS);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TEST = 3'b010,
    ST_TAIL = 3'b100
  } st_t;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic dram_pins_t encode(input cmd_t c, input logic [1:0] b,
                                        input logic [13:0] a);
    dram_pins_t p;
    p = '{cs_b: 1'b0, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, ba: b, a: a};
    case (c)
      CMD_ACT: p.ras_b = 1'b0;
      CMD_RD: p.cas_b = 1'b0;
      CMD_WR: begin
        p.cas_b = 1'b0;
        p.we_b = 1'b0;
      end
      CMD_PRE: begin
        p.ras_b = 1'b0;
        p.we_b = 1'b0;
      end
      CMD_REF: begin
        p.ras_b = 1'b0;
        p.cas_b = 1'b0;
      end
      CMD_MRS: begin
        p.ras_b = 1'b0;
        p.cas_b = 1'b0;
        p.we_b = 1'b0;
      end
      default: p.cs_b = 1'b1;
    endcase
    return p;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Per-bank timers
  logic [3:0] act_bank, close_bank, rw_ok, act_ok, pre_ok, row_open, row_exp;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      bank_timer #(.ROW_MAX_CYC(ROW_MAX_CYC)) u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .act(act_bank[g]),
        .close(close_bank[g]),
        .close_wait(RP_C),
        .rw_ok(rw_ok[g]),
        .act_ok(act_ok[g]),
        .pre_ok(pre_ok[g]),
        .row_open(row_open[g]),
        .row_expiring(row_exp[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  st_t st_q, st_d;
  logic [7:0] tcnt_q, tcnt_d;
  logic [6:0] gap_q, gap_d;
  logic [31:0] refi_q, refi_d;
  logic ref_due_q, ref_due_d, ready_q, ready_d, busy_q, busy_d;
  logic [7:0] rd_sr_q, rd_sr_d;
  dram_pins_t pins_q, pins_d;
  cmd_t issue;
  logic [1:0] ib;
  logic [13:0] ia;
  logic ok;
  logic [1:0] tb;
  logic [2:0] tphase;
  always_comb begin
    st_d = st_q;
    tcnt_d = tcnt_q;
    issue = CMD_NOP;
    ib = pins_q.ba;
    ia = pins_q.a;
    gap_d = (gap_q == 7'h00) ? 7'h00 : gap_q - 7'h01;
    refi_d = refi_q + 32'h1;
    ref_due_d = ref_due_q || refi_q + 32'h1 >= 32'(hot ? REFI_HOT_CYC : REFI_CYC);
    ready_d = 1'b0;
    ok = 1'b0;
    tb = tcnt_q[7:6];
    tphase = 3'h0;
    case (st_q)
      ST_IDLE: begin
        if (gap_q <= 7'h01 && ref_due_q) begin
          if (row_open == 4'h0) begin
            issue = CMD_REF;
            ref_due_d = 1'b0;
            refi_d = 32'h0;
          end else begin
            // Close one open bank first; a refresh needs every row shut
            for (int i = 3; i >= 0; i--) begin
              if (row_open[i] && pre_ok[i]) begin
                issue = CMD_PRE;
                ib = 2'(i);
                ia[10] = 1'b0;
              end
            end
          end
        end else if (gap_q <= 7'h01 && (row_exp & pre_ok) != 4'h0) begin
          for (int i = 3; i >= 0; i--) begin
            if (row_exp[i] && pre_ok[i]) begin
              issue = CMD_PRE;
              ib = 2'(i);
              // Bit 10 left over from an earlier command would widen this to all banks
              ia[10] = 1'b0;
            end
          end
        end else if (gap_q <= 7'h01 && test_start && row_open == 4'h0) begin
          st_d = ST_TEST;
          tcnt_d = 8'h00;
        end else if (gap_q <= 7'h01 && req_valid && !ready_q) begin
          case (req.cmd)
            CMD_ACT: ok = act_ok[req.bank];
            CMD_RD, CMD_WR: ok = rw_ok[req.bank];
            // Bit 10 asks for all banks; a closed bank takes a precharge as a no-op
            CMD_PRE: ok = req.addr[10] ? ((row_open & ~pre_ok) == 4'h0)
                                       : (!row_open[req.bank] || pre_ok[req.bank]);
            CMD_REF, CMD_MRS: ok = (row_open == 4'h0);
            default: ok = 1'b1;
          endcase
          if (ok) begin
            issue = req.cmd;
            ib = req.bank;
            ia = req.addr;
            if (req.cmd == CMD_RD || req.cmd == CMD_WR) ia[10] = req.auto_pre;
            ready_d = 1'b1;
            if (req.cmd == CMD_REF) begin
              ref_due_d = 1'b0;
              refi_d = 32'h0;
            end
          end
        end
      end
      ST_TEST: begin
        // Each bank slot: activate, wait, read with auto-precharge, four deselects
        tb = 2'(tcnt_q / 8'(2 + `TEST_DESELECTS));
        tphase = 3'(tcnt_q % 8'(2 + `TEST_DESELECTS));
        // Deselects keep the read's address, so the bus stays still between commands
        if (tphase == 3'h0) begin
          if (act_ok[tb]) begin
            issue = CMD_ACT;
            ib = tb;
            ia = 14'h0000;
            tcnt_d = tcnt_q + 8'h01;
          end
        end else if (tphase == 3'h1) begin
          if (rw_ok[tb]) begin
            issue = CMD_RD;
            ib = tb;
            ia = 14'h0400;
            tcnt_d = tcnt_q + 8'h01;
          end
        end else begin
          tcnt_d = tcnt_q + 8'h01;
        end
        if (tcnt_q == 8'(4 * (2 + `TEST_DESELECTS) - 1)) st_d = ST_TAIL;
      end
      ST_TAIL: begin
        tcnt_d = tcnt_q + 8'h01;
        if (tcnt_q >= TEST_LEN - 8'h01) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (issue == CMD_REF) gap_d = RFC_C;
    else if (issue == CMD_MRS) gap_d = MRD_C;
    // Deselects keep bank and address from the last command
    pins_d = encode(issue, ib, ia);
    busy_d = (st_d != ST_IDLE);
    // Count from the read on the pins, so the flag lands seven cycles after it
    rd_sr_d = {rd_sr_q[6:0],
               !pins_q.cs_b && pins_q.ras_b && !pins_q.cas_b && pins_q.we_b};
  end
  // Auto-precharge closes the row; the bank then waits precharge time before its next
  // activate, which bank_timer folds into the activate spacing.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      act_bank[i] = (issue == CMD_ACT) && ib == 2'(i);
      close_bank[i] = ((issue == CMD_PRE) && (ia[10] || ib == 2'(i)))
                      || ((issue == CMD_RD || issue == CMD_WR) && ia[10] && ib == 2'(i));
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      tcnt_q <= 8'h00;
      gap_q <= 7'h00;
      refi_q <= 32'h0;
      ref_due_q <= 1'b0;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
      rd_sr_q <= 8'h00;
      pins_q <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, ba: 2'h0, a: 14'h0000};
    end else begin
      st_q <= st_d;
      tcnt_q <= tcnt_d;
      gap_q <= gap_d;
      refi_q <= refi_d;
      ref_due_q <= ref_due_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      rd_sr_q <= rd_sr_d;
      pins_q <= pins_d;
    end
  end
  assign req_ready = ready_q;
  assign test_busy = busy_q;
  assign rd_data_due = rd_sr_q[`READ_LATENCY_CK - 1];
  assign pins = pins_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic is_act, is_rd, is_ref, is_mrs, is_any;
  assign is_act = !pins_q.cs_b && !pins_q.ras_b && pins_q.cas_b && pins_q.we_b;
  assign is_rd = !pins_q.cs_b && pins_q.ras_b && !pins_q.cas_b && pins_q.we_b;
  assign is_ref = !pins_q.cs_b && !pins_q.ras_b && !pins_q.cas_b && pins_q.we_b;
  assign is_mrs = !pins_q.cs_b && !pins_q.ras_b && !pins_q.cas_b && !pins_q.we_b;
  assign is_any = !pins_q.cs_b;
  property p_act_to_rd;
    @(posedge core_clk) disable iff (!rst_b) is_rd |-> |($past(rw_ok) & (4'h1 << pins_q.ba));
  endproperty
  a_act_to_rd: assert property (p_act_to_rd) else $error("read too soon after activate");
  property p_ref_gap;
    @(posedge core_clk) disable iff (!rst_b) is_ref |=> !is_any;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("command inside refresh cycle time");
  property p_mrs_gap;
    @(posedge core_clk) disable iff (!rst_b) is_mrs |=> !is_any;
  endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("command too soon after mode set");
  property p_rd_lat;
    @(posedge core_clk) disable iff (!rst_b) is_rd |-> ##7 rd_data_due;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data flag not at latency");
  property p_test_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (busy_q && $past(busy_q) && pins_q.cs_b) |-> $stable(pins_q.a);
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("address moved in deselect");
  property p_ref_due;
    @(posedge core_clk) disable iff (!rst_b) $rose(ref_due_q) |-> ##[1:48] is_ref;
  endproperty
  a_ref_due: assert property (p_ref_due) else $error("refresh not served");
  property p_act_act;
    @(posedge core_clk) disable iff (!rst_b)
      is_act |=> !(is_act && pins_q.ba == $past(pins_q.ba));
  endproperty
  a_act_act: assert property (p_act_act) else $error("activates too close");
  property p_clk;
    @(posedge core_clk) CLK_IN_RANGE;
  endproperty
  a_clk: assert property (p_clk) else $error("clock range constants inconsistent");
endmodule // ddr_cmd_sequencer

// File: tb/ddr_dev_model.sv
// Purpose: behavioural memory device that polices command spacing on its pins
// Assumes: pins are sampled on the rising core_clk edge
// Notes: violations are counted, not stopped, so one run reports them all
`include "ddr_timing_defines.svh"
module ddr_dev_model import ddr_timing_pkg::*; #(
  parameter int REFI_CYC = 78,
  parameter int REFI_HOT_CYC = 39,
  parameter int ROW_MAX_CYC = 200
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command side
  input wire dram_pins_t pins,
  input wire logic hot,
  // Observed state
  output logic dq_valid,
  output logic [3:0] open_banks,
  output int viol_cnt
);
  // Slack covers closing open rows ahead of a due refresh
  localparam int SLACK = 8;
  localparam int RCD = `CYC_UP(`T_ACT_TO_RW_PS);
  localparam int RP = `CYC_UP(`T_PRE_TO_ACT_PS);
  localparam int RAS = `CYC_UP(`T_ROW_OPEN_MIN_PS);
  localparam int RC = `CYC_UP(`T_ACT_TO_ACT_PS);
  localparam int RFC = `CYC_UP(`T_REF_TO_ANY_PS);
  int cyc;
  int ref_t;
  int mrs_t;
  int lim;
  int act_t[4];
  int pre_t[4];
  logic [7:0] rd_pipe;
  logic hot_all;
  logic [3:0] c;
  assign c = {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b};
  assign dq_valid = rd_pipe[`READ_LATENCY_CK-1];
  task automatic bad(input logic v);
    if (v) viol_cnt++;
  endtask
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc = 0;
      ref_t = 0;
      mrs_t = -9;
      viol_cnt = 0;
      open_banks = '0;
      rd_pipe = '0;
      hot_all = 1'b1;
      foreach (act_t[i]) begin
        act_t[i] = -999;
        pre_t[i] = -999;
      end
    end else begin
      cyc++;
      rd_pipe = {rd_pipe[6:0], c == 4'b0101};
      hot_all &= hot;
      lim = (hot_all ? REFI_HOT_CYC : REFI_CYC) + SLACK;
      bad(cyc - ref_t > lim);
      if (!c[3]) bad(cyc - mrs_t < `T_MODE_SET_CK);
      foreach (act_t[i]) bad(open_banks[i] && cyc - act_t[i] > ROW_MAX_CYC);
      case (c)
        4'b0011: begin
          bad(open_banks[pins.ba] || cyc - pre_t[pins.ba] < RP);
          bad(cyc - act_t[pins.ba] < RC || cyc - ref_t < RFC);
          open_banks[pins.ba] = 1'b1;
          act_t[pins.ba] = cyc;
        end
        // No write strobe is modelled; a write is checked for spacing and auto-precharge like a read
        4'b0101, 4'b0100: begin
          bad(open_banks[pins.ba] && cyc - act_t[pins.ba] < RCD);
          if (pins.a[10]) begin
            open_banks[pins.ba] = 1'b0;
            pre_t[pins.ba] = cyc;
          end
        end
        4'b0010: begin
          foreach (pre_t[i]) begin
            if (open_banks[i] && (pins.a[10] || pins.ba == 2'(i))) begin
              bad(cyc - act_t[i] < RAS);
              open_banks[i] = 1'b0;
              pre_t[i] = cyc;
            end
          end
        end
        4'b0001: begin
          bad(|open_banks || cyc - ref_t < RFC);
          ref_t = cyc;
          hot_all = 1'b1;
        end
        4'b0000: begin
          bad(|open_banks);
          mrs_t = cyc;
        end
        default: ;
      endcase
    end
  end
endmodule // ddr_dev_model

// File: tb/tb_top.sv
// Purpose: self-checking bench for the command sequencer
// Assumes: 100 ns clock, so most spacings given in time round up to one cycle
// Notes: row limit shortened to 200 cycles; refresh every 78 cycles shuts rows before it is reached
module tb_top import ddr_timing_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ROW_MAX = 200;
  localparam int REFI = 78;
  localparam int REFI_HOT = 39;
  localparam int RCD_CK = (13125 + 99999) / 100000;
  // Four deselects sit between a read and the next activate
  localparam int GAP_CK = 5;
  typedef struct packed {
    logic [31:0] t;
    logic [3:0] c;
    logic [1:0] ba;
    logic ap;
  } tev_t;
  logic core_clk, rst_b, req_valid, hot, test_start, req_ready, test_busy;
  logic rd_data_due, dq_valid, in_test, ap;
  logic [3:0] open_banks, pc;
  logic [1:0] b;
  logic [13:0] ad;
  logic [31:0] r;
  logic [15:0] last_pin;
  cmd_req_t req;
  dram_pins_t pins;
  int viol_cnt, error_cnt, compares, seed, tcyc, n_ref, since_ref;
  tev_t tq[$];
  ddr_cmd_sequencer #(.REFI_CYC(REFI), .REFI_HOT_CYC(REFI_HOT), .ROW_MAX_CYC(ROW_MAX)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .hot(hot),
    .test_start(test_start), .req_ready(req_ready), .test_busy(test_busy),
    .rd_data_due(rd_data_due), .pins(pins));
  ddr_dev_model #(.REFI_CYC(REFI), .REFI_HOT_CYC(REFI_HOT), .ROW_MAX_CYC(ROW_MAX)) dev (
    .core_clk(core_clk), .rst_b(rst_b), .pins(pins), .hot(hot), .dq_valid(dq_valid),
    .open_banks(open_banks), .viol_cnt(viol_cnt));
  assign pc = {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b};
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [3:0] enc(input cmd_t c);
    case (c)
      CMD_ACT: return 4'b0011;
      CMD_RD: return 4'b0101;
      CMD_WR: return 4'b0100;
      CMD_PRE: return 4'b0010;
      CMD_REF: return 4'b0001;
      CMD_MRS: return 4'b0000;
      default: return 4'b1111;
    endcase
  endfunction
  // Valid stays up after ready so the next call can follow back to back
  task automatic issue(input cmd_t c, input logic [1:0] bk, input logic a, input logic [13:0] d);
    int n;
    n = 0;
    req = '{cmd: c, bank: bk, auto_pre: a, addr: d};
    req_valid = 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    check(n < 400, 1);
    check({pc, pins.ba, pins.a}, {enc(c), bk, d});
  endtask
  task automatic idle(input int k);
    req_valid = 1'b0;
    repeat (k) @(negedge core_clk);
  endtask
  always @(negedge core_clk) begin
    if (rst_b) check(rd_data_due, dq_valid);
    if (pc == 4'b0001) n_ref++;
    since_ref = (pc == 4'b0001) ? 0 : since_ref + 1;
    if (test_busy === 1'b1) begin
      if (pc[3] == 1'b0) tq.push_back({tcyc, pc, pins.ba, pins.a[10]});
      else if (in_test) check({pins.ba, pins.a}, last_pin);
      last_pin = {pins.ba, pins.a};
      tcyc++;
    end
    in_test = test_busy;
  end
  initial begin
    seed = 32'h561f033e;
    {rst_b, req_valid, hot, test_start, in_test} = '0;
    req = '0;
    {error_cnt, compares, n_ref, tcyc, since_ref} = '0;
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    issue(CMD_PRE, 2'h0, 1'b1, 14'h0400);
    issue(CMD_MRS, 2'h0, 1'b0, 14'h0073);
    issue(CMD_ACT, 2'h1, 1'b0, 14'h3fff);
    issue(CMD_RD, 2'h1, 1'b0, 14'h0000);
    issue(CMD_WR, 2'h1, 1'b1, 14'h0400);
    issue(CMD_ACT, 2'h1, 1'b0, 14'h0001);
    idle(1);
    $display("test corner done");
    for (int i = 0; i < 150; i++) begin
      // A due refresh may shut the row that a pending access needs, so wait it out
      while (since_ref >= REFI - 12) @(negedge core_clk);
      r = $random(seed);
      b = r[11:10];
      ad = r[25:12];
      ap = r[2];
      ad[10] = ap;
      if (!open_banks[b]) issue(CMD_ACT, b, 1'b0, ad);
      else if (r[1:0] == 2'd0) issue(CMD_PRE, b, 1'b0, ad & 14'h3bff);
      else issue(r[0] ? CMD_RD : CMD_WR, b, ap, ad);
      idle(r[5:3] == 3'd0 ? 1 + int'(r[9:6]) : 1);
    end
    $display("test random done");
    for (int h = 0; h < 2; h++) begin
      hot = h[0];
      idle(100);
      n_ref = 0;
      idle(390);
      check(n_ref >= (h ? 390 / REFI_HOT : 390 / REFI) - 1, 1);
    end
    hot = 1'b0;
    $display("test refresh done");
    issue(CMD_PRE, 2'h0, 1'b1, 14'h0400);
    idle(1);
    n_ref = 0;
    for (int k = 0; k < 200 && n_ref == 0; k++) @(negedge core_clk);
    test_start = 1'b1;
    for (int k = 0; k < 50 && test_busy !== 1'b1; k++) @(negedge core_clk);
    test_start = 1'b0;
    for (int k = 0; k < 300 && test_busy === 1'b1; k++) @(negedge core_clk);
    check(tq.size(), 8);
    if (tq.size() >= 8) for (int k = 0; k < 4; k++) begin
      check({tq[2*k].c, tq[2*k].ba}, {4'b0011, k[1:0]});
      check({tq[2*k+1].c, tq[2*k+1].ba, tq[2*k+1].ap}, {4'b0101, k[1:0], 1'b1});
      check(tq[2*k+1].t - tq[2*k].t, RCD_CK);
      if (k < 3) check(tq[2*k+2].t - tq[2*k+1].t, GAP_CK);
    end
    $display("test interleave done");
    check(viol_cnt, 0);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
endmodule // tb_top
